// ---- dv/cmch_bus_model.sv ----
// can bus model: wired-and of our tx pin and the other nodes
// assumes bench raises dom_req to have a remote node drive dominant
`timescale 1ns/100ps
module cmch_bus_model (
   input  wire logic pclk,
   input  wire logic bus_tx_pin,
   input  wire logic dom_req,
   output logic      bus_rx_pin
);
   // released bus floats recessive through the termination, never x
   assign bus_rx_pin = bus_tx_pin & ~dom_req;
endmodule

// ---- dv/tb_cmch_top.sv ----
// bench for cmch_top: apb register tests plus can bus model
// assumes an apb slave that answers through pready, and a shortened wake filter
`timescale 1ns/100ps
module tb_cmch_top;
   import cmch_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, engine_tx, bus_idle, tx_empty;
   logic cpu_stop, cpu_wait, dom_req, bus_rx_pin, bus_tx_pin, engine_rx, pready;
   logic ack_slot_ignore, tx_allowed, err_count_freeze, bus_clk_gate, engine_reset;
   logic special_mode, pslverr, ack_err_allowed, wake_event;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  tx_status_field, rx_status_field;
   cmch_mode_t  mode;
   int          mismatches, comparisons;

   cmch_top #(.WAKE_CYC(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .special_mode(special_mode), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
      .bus_rx_pin(bus_rx_pin), .bus_tx_pin(bus_tx_pin), .engine_tx(engine_tx),
      .engine_rx(engine_rx), .bus_idle(bus_idle), .tx_empty(tx_empty),
      .tx_status_field(tx_status_field), .rx_status_field(rx_status_field), .mode(mode),
      .engine_reset(engine_reset), .tx_allowed(tx_allowed), .ack_err_allowed(ack_err_allowed),
      .err_count_freeze(err_count_freeze), .ack_slot_ignore(ack_slot_ignore),
      .bus_clk_gate(bus_clk_gate), .wake_event(wake_event));
   cmch_bus_model bus (.pclk(pclk), .bus_tx_pin(bus_tx_pin), .dom_req(dom_req), .bus_rx_pin(bus_rx_pin));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // values read right after an edge are the ones the edge sampled
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      chk("pslverr", {31'h0, pslverr}, 32'h0);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(name, rd, exp);
   endtask

   task automatic settle();
      @(posedge pclk);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      #200us;
      mismatches++;
      results();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata, cpu_stop, cpu_wait, dom_req, special_mode} = '0;
      {engine_tx, bus_idle, tx_empty, presetn} = 4'b1110;
      tx_status_field = 2'b10;
      rx_status_field = 2'b01;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rchk("ctl1 reset", CMCH_OFF_CTL1, 32'h11);
      rchk("ctl0 reset", CMCH_OFF_CTL0, 32'h01);
      $display("test reset done");
      // in init: loopback, clock source, recovery, enable
      apb(1'b1, CMCH_OFF_CTL1, 32'he8);
      rchk("ctl1 cfg", CMCH_OFF_CTL1, 32'he9);
      engine_tx <= 1'b0;
      settle();
      chk("mode", {27'h0, mode}, 32'h1d);
      chk("loop rx", {31'h0, engine_rx}, 32'h0);
      chk("loop tx", {31'h0, bus_tx_pin}, 32'h1);
      chk("ack ign", {31'h0, ack_slot_ignore}, 32'h1);
      // enable is write-once: clearing it must not stick
      apb(1'b1, CMCH_OFF_CTL1, 32'h14);
      rchk("ctl1 once", CMCH_OFF_CTL1, 32'h95);
      settle();
      chk("listen tx", {31'h0, tx_allowed}, 32'h0);
      chk("freeze", {31'h0, err_count_freeze}, 32'h1);
      chk("ack err", {31'h0, ack_err_allowed}, 32'h0);
      apb(1'b1, CMCH_OFF_CTL1, 32'h84);
      apb(1'b1, CMCH_OFF_BT0, 32'h5a);
      rchk("bt0 init", CMCH_OFF_BT0, 32'h5a);
      $display("test init config done");
      apb(1'b1, CMCH_OFF_CTL0, 32'h00);
      rchk("ctl1 run", CMCH_OFF_CTL1, 32'h84);
      apb(1'b1, CMCH_OFF_BT0, 32'h33);
      apb(1'b1, CMCH_OFF_CTL1, 32'h00);
      rchk("bt0 prot", CMCH_OFF_BT0, 32'h5a);
      rchk("ctl1 prot", CMCH_OFF_CTL1, 32'h84);
      rchk("unmapped", 12'h07c, 32'h0);
      settle();
      chk("tx run", {31'h0, bus_tx_pin}, 32'h0);
      cpu_wait <= 1'b1;
      settle();
      chk("wait nostop", {31'h0, bus_tx_pin}, 32'h0);
      apb(1'b1, CMCH_OFF_CTL0, 32'h20);
      settle();
      chk("wait tx", {31'h0, bus_tx_pin}, 32'h1);
      chk("clk gate", {31'h0, bus_clk_gate}, 32'h0);
      cpu_wait <= 1'b0;
      cpu_stop <= 1'b1;
      settle();
      chk("stop tx", {31'h0, bus_tx_pin}, 32'h1);
      cpu_stop  <= 1'b0;
      engine_tx <= 1'b1;
      $display("test protect and low power done");
      // sleep held off while bus busy, clear ignored until acknowledged
      {bus_idle, tx_empty} <= 2'b00;
      apb(1'b1, CMCH_OFF_CTL0, 32'h06);
      rchk("no sleep_ack", CMCH_OFF_CTL1, 32'h84);
      apb(1'b1, CMCH_OFF_CTL0, 32'h04);
      rchk("sleep_request kept", CMCH_OFF_CTL0, 32'h06);
      {bus_idle, tx_empty} <= 2'b11;
      rchk("sleep_ack", CMCH_OFF_CTL1, 32'h86);
      dom_req <= 1'b1;
      repeat (2) @(posedge pclk);
      dom_req <= 1'b0;
      rchk("short pulse", CMCH_OFF_CTL1, 32'h86);
      dom_req <= 1'b1;
      repeat (8) @(posedge pclk);
      dom_req <= 1'b0;
      rchk("woken ack", CMCH_OFF_CTL1, 32'h84);
      rchk("woken req", CMCH_OFF_CTL0, 32'h04);
      $display("test sleep and wake done");
      // init entry from sleep keeps only wake enable and the requests
      apb(1'b1, CMCH_OFF_CTL0, 32'h0e);
      rchk("sleep_ack again", CMCH_OFF_CTL1, 32'h86);
      apb(1'b1, CMCH_OFF_CTL0, 32'h0f);
      engine_tx <= 1'b0;
      settle();
      chk("init tx", {31'h0, bus_tx_pin}, 32'h1);
      chk("eng rst", {31'h0, engine_reset}, 32'h1);
      rchk("ctl0 init", CMCH_OFF_CTL0, 32'h07);
      rchk("ctl1 init", CMCH_OFF_CTL1, 32'h87);
      rchk("status", CMCH_OFF_STAT, 32'h09);
      $display("test init entry done");
      // special mode: enable freely writable in init; unfiltered wake
      special_mode <= 1'b1;
      apb(1'b1, CMCH_OFF_CTL1, 32'h00);
      rchk("on special", CMCH_OFF_CTL1, 32'h03);
      chk("mode off", {27'h0, mode}, 32'h0);
      apb(1'b1, CMCH_OFF_CTL1, 32'h80);
      special_mode <= 1'b0;
      rchk("on again", CMCH_OFF_CTL1, 32'h83);
      engine_tx <= 1'b1;
      apb(1'b1, CMCH_OFF_CTL0, 32'h06);
      rchk("back to sleep", CMCH_OFF_CTL1, 32'h82);
      dom_req <= 1'b1;
      settle();
      chk("wake evt", {31'h0, wake_event}, 32'h1);
      dom_req <= 1'b0;
      rchk("fast wake", CMCH_OFF_CTL1, 32'h80);
      // wake disabled: traffic ignored, cpu clear allowed once acknowledged
      apb(1'b1, CMCH_OFF_CTL0, 32'h02);
      rchk("sleep_ack nowake", CMCH_OFF_CTL1, 32'h82);
      dom_req <= 1'b1;
      settle();
      chk("no wake evt", {31'h0, wake_event}, 32'h0);
      dom_req <= 1'b0;
      rchk("wake ignored", CMCH_OFF_CTL1, 32'h82);
      apb(1'b1, CMCH_OFF_CTL0, 32'h00);
      rchk("sleep left", CMCH_OFF_CTL1, 32'h80);
      $display("test special mode and wake options done");
      results();
   end
endmodule

// ---- src/cmch_pkg.sv ----
// package for the can mode-control and handshake block
// assumes a 32-bit apb slave with one register per aligned word
package cmch_pkg;
   localparam logic [11:0] CMCH_OFF_CTL0   = 12'h000;
   localparam logic [11:0] CMCH_OFF_CTL1   = 12'h004;
   localparam logic [11:0] CMCH_OFF_BT0    = 12'h008;
   localparam logic [11:0] CMCH_OFF_BT1    = 12'h00c;
   localparam logic [11:0] CMCH_OFF_IDAC   = 12'h010;
   localparam logic [11:0] CMCH_OFF_IDAR   = 12'h020;
   localparam logic [11:0] CMCH_OFF_IDMR   = 12'h040;
   localparam logic [11:0] CMCH_OFF_STAT   = 12'h060;
   localparam int          CMCH_NUM_ID     = 8;

   // primary_mode_control bit positions
   localparam int CMCH_C0_INIT_REQUEST = 0;
   localparam int CMCH_C0_SLEEP_REQUEST  = 1;
   localparam int CMCH_C0_WAKE_ENABLE   = 2;
   localparam int CMCH_C0_WCS    = 5;
   // mode_config_handshake bit positions
   localparam int CMCH_C1_ON     = 7;
   localparam int CMCH_C1_CLK    = 6;
   localparam int CMCH_C1_LOOP   = 5;
   localparam int CMCH_C1_LISTEN = 4;
   localparam int CMCH_C1_BUSOFF_RECOVERY_SELECT   = 3;
   localparam int CMCH_C1_WAKE_FILTER_SELECT   = 2;
   localparam int CMCH_C1_SLEEP_ACK  = 1;
   localparam int CMCH_C1_INIT_ACK = 0;

   localparam logic [7:0] CMCH_C0_RESET = 8'h01;
   localparam logic [7:0] CMCH_C1_RESET = 8'h11;
   localparam logic [7:0] CMCH_C0_KEEP  = 8'h07;
   localparam logic [7:0] CMCH_C1_WMASK = 8'hfc;

   localparam int CMCH_CLK_MHZ       = 25;
   localparam int CMCH_WAKE_PULSE_NS = 2000;
   localparam int CMCH_WAKE_CYC      = (CMCH_WAKE_PULSE_NS * CMCH_CLK_MHZ + 999) / 1000;

   typedef struct packed {
      logic on;
      logic clk_bus;
      logic loopback;
      logic listen;
      logic busoff_user;
   } cmch_mode_t;

   typedef enum logic [1:0] {
      CMCH_RUN   = 2'b00,
      CMCH_INIT  = 2'b01,
      CMCH_SLEEP = 2'b10
   } cmch_state_t;
endpackage

// ---- src/cmch_top.sv ----
// mode control, sleep/init handshakes and tx forcing of a can controller
// assumes apb master on pclk; protocol engine status arrives as plain inputs
//
// Operation
// RULE1 - tx pin recessive on stop, or wait with wait clock stop set
// RULE2 - cpu clear of sleep request ignored until sleep entered
// RULE3 - cpu clear of init request ignored until init entered
// RULE4 - tx pin recessive as soon as init is requested
// RULE5 - software should enter sleep before requesting init
// RULE6 - init reset of control 0 keeps wake enable, init and sleep requests
// RULE7 - tx and rx status fields survive init entry
// RULE8 - control 1 readable always, writable in init; enable write-once normally
// RULE9 - control 1 bit 7 enables the controller
// RULE10 - control 1 bit 6 selects oscillator or bus clock
// RULE11 - loopback feeds tx to rx, ignores rx pin, holds tx recessive
// RULE12 - loopback ignores ack slot, own frame counts as received
// RULE13 - listen only: no ack or error frames, error counters frozen
// RULE14 - listen only: no transmission
// RULE15 - control 1 bit 3 picks automatic or user bus-off recovery
// RULE16 - wake filter bit picks any dominant or minimum length pulse
// RULE17 - sleep ack read-only, set on entry, cleared by wake-up
// RULE18 - init ack read-only; init active when request and ack both 1
// RULE19 - timing, acceptance and mask registers writable only in init
// RULE20 - software sets wake enable and wake irq enable for recovery
// RULE21 - sleep serviced only with bus idle and tx buffers empty; in init sleep_ack is set without checking them
// RULE22 - init aborts traffic, drops sync, resets engine registers
// RULE23 - wake enable lets bus traffic restart from sleep
// RULE24 - wait clock stop halts bus interface clock in wait
`timescale 1ns/100ps
module cmch_top
   import cmch_pkg::*;
#(
   parameter int WAKE_CYC = CMCH_WAKE_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        special_mode,
   input  wire logic        cpu_stop,
   input  wire logic        cpu_wait,
   input  wire logic        bus_rx_pin,
   output logic             bus_tx_pin,
   input  wire logic        engine_tx,
   output logic             engine_rx,
   input  wire logic        bus_idle,
   input  wire logic        tx_empty,
   input  wire logic [1:0]  tx_status_field,
   input  wire logic [1:0]  rx_status_field,
   output cmch_mode_t       mode,
   output logic             engine_reset,
   output logic             tx_allowed,
   output logic             ack_err_allowed,
   output logic             err_count_freeze,
   output logic             ack_slot_ignore,
   output logic             bus_clk_gate,
   output logic             wake_event
);
   logic [7:0] ctl0;
   logic       init_ack;
   logic       sleep_ack;
   logic [7:0] ctl1;
   logic       on_written;
   logic [7:0] bt0;
   logic [7:0] bt1;
   logic [7:0] idac;
   logic [7:0] idar [CMCH_NUM_ID];
   logic [7:0] idmr [CMCH_NUM_ID];
   logic [15:0] wake_cnt;
   cmch_state_t state;

   logic wr;
   logic in_init;
   logic in_sleep;
   logic wake_seen;
   logic [7:0] wb;
   logic [2:0] idx;
   logic       hit_idar;
   logic       hit_idmr;

   assign wr       = psel & penable & pwrite;
   assign wb       = pwdata[7:0];
   assign idx      = paddr[4:2];
   assign hit_idar = paddr[11:5] == CMCH_OFF_IDAR[11:5];
   assign hit_idmr = paddr[11:5] == CMCH_OFF_IDMR[11:5];
   assign in_init  = ctl0[CMCH_C0_INIT_REQUEST] & init_ack; // RULE18
   assign in_sleep = ctl0[CMCH_C0_SLEEP_REQUEST] & sleep_ack;
   assign pready   = 1'b1;
   assign pslverr  = 1'b0;

   // primary_mode_control: cpu may only clear requests once acknowledged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl0 <= CMCH_C0_RESET;
      end else begin
         if (wr && paddr == CMCH_OFF_CTL0) begin
            ctl0 <= wb;
            if (!wb[CMCH_C0_SLEEP_REQUEST] && ctl0[CMCH_C0_SLEEP_REQUEST] && !sleep_ack) begin
               ctl0[CMCH_C0_SLEEP_REQUEST] <= 1'b1; // RULE2
            end
            if (!wb[CMCH_C0_INIT_REQUEST] && ctl0[CMCH_C0_INIT_REQUEST] && !init_ack) begin
               ctl0[CMCH_C0_INIT_REQUEST] <= 1'b1; // RULE3
            end
            if (ctl0[CMCH_C0_INIT_REQUEST]) begin
               // other bits held at reset while init requested
               ctl0 <= (CMCH_C0_RESET & ~CMCH_C0_KEEP) | (ctl0 & CMCH_C0_KEEP); // RULE6
               ctl0[CMCH_C0_INIT_REQUEST] <= wb[CMCH_C0_INIT_REQUEST] | ~init_ack; // RULE3
               ctl0[CMCH_C0_SLEEP_REQUEST]  <= wb[CMCH_C0_SLEEP_REQUEST] | (ctl0[CMCH_C0_SLEEP_REQUEST] & ~sleep_ack); // RULE2
               ctl0[CMCH_C0_WAKE_ENABLE]   <= wb[CMCH_C0_WAKE_ENABLE];
            end
         end else if (ctl0[CMCH_C0_INIT_REQUEST]) begin
            ctl0 <= (CMCH_C0_RESET & ~CMCH_C0_KEEP) | (ctl0 & CMCH_C0_KEEP); // RULE6 RULE22
         end
         if (in_sleep && wake_seen && ctl0[CMCH_C0_WAKE_ENABLE]) begin
            ctl0[CMCH_C0_SLEEP_REQUEST] <= 1'b0; // RULE23
         end
      end
   end

   // handshake state: init takes priority, sleep from run waits for idle bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= CMCH_INIT;
         init_ack  <= 1'b1;
         sleep_ack <= 1'b0;
      end else begin
         unique case (state)
            CMCH_RUN: begin
               if (ctl0[CMCH_C0_INIT_REQUEST]) begin
                  state    <= CMCH_INIT; // RULE22
                  init_ack <= 1'b1;
               end else if (ctl0[CMCH_C0_SLEEP_REQUEST] && bus_idle && tx_empty) begin
                  state     <= CMCH_SLEEP; // RULE21
                  sleep_ack <= 1'b1; // RULE17
               end
            end
            CMCH_SLEEP: begin
               if (ctl0[CMCH_C0_INIT_REQUEST]) begin
                  state    <= CMCH_INIT;
                  init_ack <= 1'b1;
               end else if (!ctl0[CMCH_C0_SLEEP_REQUEST] || (ctl0[CMCH_C0_WAKE_ENABLE] && wake_seen)) begin
                  state     <= CMCH_RUN;
                  sleep_ack <= 1'b0; // RULE17 RULE23
               end
            end
            CMCH_INIT: begin
               if (!ctl0[CMCH_C0_INIT_REQUEST]) begin
                  state    <= ctl0[CMCH_C0_SLEEP_REQUEST] && sleep_ack ? CMCH_SLEEP : CMCH_RUN;
                  init_ack <= 1'b0;
               end else if (ctl0[CMCH_C0_SLEEP_REQUEST] && !sleep_ack) begin
                  sleep_ack <= 1'b1;
               end else if (!ctl0[CMCH_C0_SLEEP_REQUEST]) begin
                  sleep_ack <= 1'b0;
               end
            end
            default: begin
               state <= CMCH_INIT;
            end
         endcase
      end
   end

   // wake filter: dominant is 0; filtered mode needs a full pulse length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt <= 16'h0000;
      end else if (in_sleep && !bus_rx_pin && wake_cnt < 16'(WAKE_CYC)) begin
         wake_cnt <= wake_cnt + 16'h0001;
      end else if (!in_sleep || bus_rx_pin) begin
         wake_cnt <= 16'h0000;
      end
   end
   assign wake_seen  = ctl1[CMCH_C1_WAKE_FILTER_SELECT] ? (wake_cnt >= 16'(WAKE_CYC)) // RULE16
                                          : (in_sleep && !bus_rx_pin);
   assign wake_event = in_sleep & ctl0[CMCH_C0_WAKE_ENABLE] & wake_seen;

   // mode_config_handshake: writable in init only, enable write-once normally
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl1       <= CMCH_C1_RESET;
         on_written <= 1'b0;
      end else begin
         if (wr && paddr == CMCH_OFF_CTL1 && in_init) begin // RULE8 RULE19
            ctl1[CMCH_C1_CLK:CMCH_C1_WAKE_FILTER_SELECT] <= wb[CMCH_C1_CLK:CMCH_C1_WAKE_FILTER_SELECT];
            if (special_mode || !on_written) begin
               ctl1[CMCH_C1_ON] <= wb[CMCH_C1_ON]; // RULE8
               on_written       <= 1'b1;
            end
         end
      end
   end

   // timing and acceptance registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bt0  <= 8'h00;
         bt1  <= 8'h00;
         idac <= 8'h00;
         for (int i = 0; i < CMCH_NUM_ID; i++) begin
            idar[i] <= 8'h00;
            idmr[i] <= 8'h00;
         end
      end else if (wr && in_init) begin // RULE19
         if (paddr == CMCH_OFF_BT0) bt0 <= wb;
         if (paddr == CMCH_OFF_BT1) bt1 <= wb;
         if (paddr == CMCH_OFF_IDAC) idac <= wb;
         if (hit_idar) idar[idx] <= wb;
         if (hit_idmr) idmr[idx] <= wb;
      end
   end

   // read mux; ack bits are state, not stored copies
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= 32'h0000_0000;
         if (paddr == CMCH_OFF_CTL0) prdata[7:0] <= ctl0;
         if (paddr == CMCH_OFF_CTL1) prdata[7:0] <= {ctl1[7:2], sleep_ack, init_ack}; // RULE17 RULE18
         if (paddr == CMCH_OFF_BT0) prdata[7:0] <= bt0;
         if (paddr == CMCH_OFF_BT1) prdata[7:0] <= bt1;
         if (paddr == CMCH_OFF_IDAC) prdata[7:0] <= idac;
         if (hit_idar) prdata[7:0] <= idar[idx];
         if (hit_idmr) prdata[7:0] <= idmr[idx];
         if (paddr == CMCH_OFF_STAT) prdata[3:0] <= {tx_status_field, rx_status_field}; // RULE7
      end
   end

   assign mode.on          = ctl1[CMCH_C1_ON]; // RULE9
   assign mode.clk_bus     = ctl1[CMCH_C1_CLK]; // RULE10
   assign mode.loopback    = ctl1[CMCH_C1_LOOP];
   assign mode.listen      = ctl1[CMCH_C1_LISTEN];
   assign mode.busoff_user = ctl1[CMCH_C1_BUSOFF_RECOVERY_SELECT]; // RULE15
   assign engine_reset     = ctl0[CMCH_C0_INIT_REQUEST]; // RULE22
   assign engine_rx        = ctl1[CMCH_C1_LOOP] ? engine_tx : bus_rx_pin; // RULE11 RULE12
   assign ack_slot_ignore  = ctl1[CMCH_C1_LOOP]; // RULE12
   assign tx_allowed       = ~ctl1[CMCH_C1_LISTEN] & ~engine_reset; // RULE14
   assign ack_err_allowed  = ~ctl1[CMCH_C1_LISTEN]; // RULE13
   assign err_count_freeze = ctl1[CMCH_C1_LISTEN]; // RULE13
   assign bus_clk_gate     = ~(cpu_wait & ctl0[CMCH_C0_WCS]); // RULE24

   always_comb begin
      bus_tx_pin = engine_tx;
      if (cpu_stop || (cpu_wait && ctl0[CMCH_C0_WCS])) bus_tx_pin = 1'b1; // RULE1
      if (ctl0[CMCH_C0_INIT_REQUEST]) bus_tx_pin = 1'b1; // RULE4
      if (ctl1[CMCH_C1_LOOP] || ctl1[CMCH_C1_LISTEN] || !ctl1[CMCH_C1_ON]) bus_tx_pin = 1'b1; // RULE11 RULE14
   end

   property p_tx_init;
      @(posedge pclk) disable iff (!presetn) ctl0[CMCH_C0_INIT_REQUEST] |-> bus_tx_pin;
   endproperty
   a_tx_init: assert property (p_tx_init) else $error("tx not recessive in init"); // RULE4

   property p_tx_stop;
      @(posedge pclk) disable iff (!presetn) cpu_stop |-> bus_tx_pin;
   endproperty
   a_tx_stop: assert property (p_tx_stop) else $error("tx not recessive in stop"); // RULE1

   property p_slp_hold;
      @(posedge pclk) disable iff (!presetn)
         (ctl0[CMCH_C0_SLEEP_REQUEST] && !sleep_ack && !wake_event) |=> ctl0[CMCH_C0_SLEEP_REQUEST];
   endproperty
   a_slp_hold: assert property (p_slp_hold) else $error("sleep request dropped early"); // RULE2

   property p_init_hold;
      @(posedge pclk) disable iff (!presetn) (ctl0[CMCH_C0_INIT_REQUEST] && !init_ack) |=> ctl0[CMCH_C0_INIT_REQUEST];
   endproperty
   a_init_hold: assert property (p_init_hold) else $error("init request dropped early"); // RULE3

   property p_ctl1_lock;
      @(posedge pclk) disable iff (!presetn) !in_init |=> $stable(ctl1);
   endproperty
   a_ctl1_lock: assert property (p_ctl1_lock) else $error("control 1 changed outside init"); // RULE8

   property p_bt_lock;
      @(posedge pclk) disable iff (!presetn) !in_init |=> ($stable(bt0) && $stable(bt1) && $stable(idac));
   endproperty
   a_bt_lock: assert property (p_bt_lock) else $error("timing register changed outside init"); // RULE19

   property p_sleep_idle;
      @(posedge pclk) disable iff (!presetn)
         ($past(state) == CMCH_RUN && $rose(sleep_ack)) |-> $past(bus_idle && tx_empty);
   endproperty
   a_sleep_idle: assert property (p_sleep_idle) else $error("sleep entered with busy bus"); // RULE21

   property p_loop_rx;
      @(posedge pclk) disable iff (!presetn) ctl1[CMCH_C1_LOOP] |-> (engine_rx == engine_tx && bus_tx_pin);
   endproperty
   a_loop_rx: assert property (p_loop_rx) else $error("loopback path wrong"); // RULE11

   property p_listen;
      @(posedge pclk) disable iff (!presetn) ctl1[CMCH_C1_LISTEN] |-> (!tx_allowed && bus_tx_pin && err_count_freeze);
   endproperty
   a_listen: assert property (p_listen) else $error("listen only transmitted"); // RULE14
endmodule
